// file: dscml_pkg.sv
package dscml_pkg;

   // Pin bus widths
   localparam int DQ_W = 8;
   localparam int A_W  = 13;
   localparam int BA_W = 2;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_MODE   = 8'h04;
   localparam logic [7:0] OFS_EMODE  = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_REFROW = 8'h10;
   localparam logic [3:0] OFS_ROWS_HI = 4'h2;

   // Control and status bits
   localparam int CTRL_EN        = 0;
   localparam int ST_DLL_READY   = 0;
   localparam int ST_SELF_REF    = 1;
   localparam int ST_RD_ACT      = 2;
   localparam int ST_WR_ACT      = 3;
   localparam int ST_OPEN_LSB    = 4;
   localparam int ST_CMD_LSB     = 8;

   // Mode register fields
   localparam int MR_BL_LSB   = 0;
   localparam int MR_BT       = 3;
   localparam int MR_CL_LSB   = 4;
   localparam int MR_DLL_RST  = 8;
   localparam int EMR_DLL_DIS = 0;
   localparam int ADDR_AP     = 10;

   // Burst length and latency codes
   localparam logic [2:0] BL_2    = 3'h1;
   localparam logic [2:0] BL_4    = 3'h2;
   localparam logic [2:0] BL_8    = 3'h3;
   localparam logic [2:0] CL_2    = 3'h2;
   localparam logic [2:0] CL_2P5  = 3'h6;
   localparam logic [2:0] LAT_HALF_CL2   = 3'h4;
   localparam logic [2:0] LAT_HALF_CL2P5 = 3'h5;

   // Link clock cycles after DLL enable before a read may follow
   localparam int DLL_LOCK_CK = 200;

   localparam logic [A_W-1:0] MODE_RST  = 13'h0000;
   localparam logic [A_W-1:0] EMODE_RST = 13'h0000;

   typedef enum logic [2:0] {
      DSCML_NOP, DSCML_ACT, DSCML_RD, DSCML_WR,
      DSCML_BST, DSCML_PRE, DSCML_REF, DSCML_LMR
   } dscml_cmd_t;

   typedef struct packed {
      logic            ck;
      logic            cke;
      logic            cs_n;
      logic            ras_n;
      logic            cas_n;
      logic            we_n;
      logic [BA_W-1:0] ba;
      logic [A_W-1:0]  a;
      logic [DQ_W-1:0] dq;
      logic            dm;
      logic            dqs;
   } dscml_pins_t;

endpackage

// file: dscml_burst_addr.sv
`timescale 1ns/1ps
module dscml_burst_addr (
   input  wire logic [9:0] start_i,
   input  wire logic [2:0] beat_i,
   input  wire logic [2:0] len_code_i,
   input  wire logic       interleave_i,
   output logic      [9:0] col_o,
   output logic      [2:0] mask_o
);

   logic [2:0] off;

   always_comb begin
      case (len_code_i)
         dscml_pkg::BL_2: begin
            mask_o = 3'h1;
         end
         dscml_pkg::BL_4: begin
            mask_o = 3'h3;
         end
         default: begin
            mask_o = 3'h7;
         end
      endcase
      if (interleave_i) begin
         off = start_i[2:0] ^ beat_i;
      end else begin
         off = 3'(start_i[2:0] + beat_i);
      end
      // Masking keeps the count inside the aligned block
      col_o = {start_i[9:3], (start_i[2:0] & ~mask_o) | (off & mask_o)};
   end

endmodule

// file: dscml_mem.sv
`timescale 1ns/1ps
module dscml_mem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input  wire logic          clk_i,
   input  wire logic          rst_n_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [DW-1:0] wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [DW-1:0] rdata_o
);

   typedef struct packed {
      logic [(1<<AW)-1:0][DW-1:0] cells;
      logic [DW-1:0]              rdata;
   } dscml_mem_state_t;

   dscml_mem_state_t s_reg;
   dscml_mem_state_t s_next;

   always_comb begin
      s_next = s_reg;
      if (we_i) begin
         s_next.cells[waddr_i] = wdata_i;
      end
      s_next.rdata = s_reg.cells[raddr_i];
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign rdata_o = s_reg.rdata;

endmodule

// file: dscml_top.sv
`timescale 1ns/1ps
// Function
// - Length eight: A3 up picks block, A0-A2 start; sequential adds, interleaved XORs.
// - Length four: A2 up picks block, two low column bits give start word.
// - Length two: A1 up picks block, A0 gives the first word.
// - Bursts wrap inside their selected block, never crossing into a neighbour.
// - Read latency is programmable to 2 or 2.5 link clocks.
// - Read at edge n with latency m drives first data at edge n+m.
// - Mode load with A7-A12 zero is normal mode, A0-A6 carry settings.
// - Load with BA0 high, BA1 low writes extended register: DLL, drive strength.
// - Leaving self refresh turns the DLL back on without any load.
// - Chip select and strobes decode to the eight commands on each rising edge.
// - Load picks base register at bank 00, extended at 01; others reserved.
// - Activate opens the row on A0-A12 in the selected bank.
// - Read and write take bank and column A0-A9; A10 asks auto precharge.
// - Precharge closes the named bank, or all banks with A10 high.
// - Refresh is auto with CKE high, self refresh entry with CKE low.
// - Data mask low lets a write beat through, high blocks it.
// - Base register: A0-A2 length, A3 type, A4-A6 latency, A7-A12 mode.
// - Mode values persist until rewritten, save the DLL disable bit that self refresh exit clears; the DLL reset bit clears itself.
module dscml_top #(
   parameter int MEM_AW          = 8,
   parameter int DLL_LOCK_CYCLES = dscml_pkg::DLL_LOCK_CK
) (
   input  wire logic                       CORE_CLK_I,
   input  wire logic                       RESET_N_I,
   input  wire logic                       CK_I,
   input  wire logic                       CKE_I,
   input  wire logic                       CS_N_I,
   input  wire logic                       RAS_N_I,
   input  wire logic                       CAS_N_I,
   input  wire logic                       WE_N_I,
   input  wire logic [dscml_pkg::BA_W-1:0] BA_I,
   input  wire logic [dscml_pkg::A_W-1:0]  A_I,
   input  wire logic [dscml_pkg::DQ_W-1:0] DQ_I,
   output logic      [dscml_pkg::DQ_W-1:0] DQ_O,
   output logic                            DQ_OE_O,
   input  wire logic                       DM_I,
   input  wire logic                       DQS_I,
   output logic                            DQS_O,
   output logic                            DQS_OE_O,
   input  wire logic                       PSEL_I,
   input  wire logic                       PENABLE_I,
   input  wire logic                       PWRITE_I,
   input  wire logic [7:0]                 PADDR_I,
   input  wire logic [31:0]                PWDATA_I,
   output logic      [31:0]                PRDATA_O,
   output logic                            PREADY_O,
   output logic                            PSLVERR_O
);

   typedef struct packed {
      dscml_pkg::dscml_pins_t           s1;
      dscml_pkg::dscml_pins_t           s2;
      logic                             ck_d;
      logic                             dqs_d;
      logic [dscml_pkg::A_W-1:0]        mode;
      logic [dscml_pkg::A_W-1:0]        emode;
      logic                             en;
      logic [3:0]                       open;
      logic [3:0][dscml_pkg::A_W-1:0]   rows;
      logic                             self_ref;
      logic [dscml_pkg::A_W-1:0]        ref_row;
      logic [7:0]                       dll_cnt;
      dscml_pkg::dscml_cmd_t            last_cmd;
      logic                             rd_act;
      logic                             rd_out;
      logic                             rd_ap;
      logic [2:0]                       rd_wait;
      logic [1:0]                       rd_bank;
      logic [9:0]                       rd_col;
      logic [2:0]                       rd_beat;
      logic                             rd_out_d;
      logic                             dqs_ph;
      logic                             wr_act;
      logic                             wr_ap;
      logic [1:0]                       wr_bank;
      logic [9:0]                       wr_col;
      logic [2:0]                       wr_beat;
      logic [dscml_pkg::DQ_W-1:0]       dq_o;
      logic                             dq_oe;
      logic                             dqs_o;
      logic                             dqs_oe;
      logic [31:0]                      prdata;
      logic                             pready;
      logic                             pslverr;
   } dscml_state_t;

   localparam logic [7:0] DLL_LOCK = 8'(DLL_LOCK_CYCLES);

   dscml_state_t           s_reg;
   dscml_state_t           s_next;
   dscml_pkg::dscml_pins_t pins_in;
   dscml_pkg::dscml_cmd_t  cmd;
   logic                   ck_rise;
   logic                   ck_edge;
   logic                   dqs_edge;
   logic                   dll_ready;
   logic [2:0]             lat_half;
   logic [9:0]             rd_addr_col;
   logic [9:0]             wr_addr_col;
   logic [2:0]             beat_mask;
   logic                   mem_we;
   logic [dscml_pkg::DQ_W-1:0] mem_rdata;

   assign pins_in = '{ck: CK_I, cke: CKE_I, cs_n: CS_N_I, ras_n: RAS_N_I, cas_n: CAS_N_I,
                      we_n: WE_N_I, ba: BA_I, a: A_I, dq: DQ_I, dm: DM_I, dqs: DQS_I};

   // Edges are found on the second sync stage only
   assign ck_rise  = s_reg.s2.ck & ~s_reg.ck_d;
   assign ck_edge  = s_reg.s2.ck ^ s_reg.ck_d;
   assign dqs_edge = s_reg.s2.dqs ^ s_reg.dqs_d;
   assign dll_ready = ~s_reg.emode[dscml_pkg::EMR_DLL_DIS] && (s_reg.dll_cnt == DLL_LOCK);

   always_comb begin
      cmd = dscml_pkg::DSCML_NOP;
      if (!s_reg.s2.cs_n) begin
         unique case ({s_reg.s2.ras_n, s_reg.s2.cas_n, s_reg.s2.we_n})
            3'h7: cmd = dscml_pkg::DSCML_NOP;
            3'h3: cmd = dscml_pkg::DSCML_ACT;
            3'h5: cmd = dscml_pkg::DSCML_RD;
            3'h4: cmd = dscml_pkg::DSCML_WR;
            3'h6: cmd = dscml_pkg::DSCML_BST;
            3'h2: cmd = dscml_pkg::DSCML_PRE;
            3'h1: cmd = dscml_pkg::DSCML_REF;
            3'h0: cmd = dscml_pkg::DSCML_LMR;
         endcase
      end
   end

   always_comb begin
      // Reserved latency codes fall back to two clocks
      if (s_reg.mode[dscml_pkg::MR_CL_LSB +: 3] == dscml_pkg::CL_2P5) begin
         lat_half = dscml_pkg::LAT_HALF_CL2P5;
      end else begin
         lat_half = dscml_pkg::LAT_HALF_CL2;
      end
   end

   dscml_burst_addr u_rd_addr (
      .start_i      (s_reg.rd_col),
      .beat_i       (s_reg.rd_beat),
      .len_code_i   (s_reg.mode[dscml_pkg::MR_BL_LSB +: 3]),
      .interleave_i (s_reg.mode[dscml_pkg::MR_BT]),
      .col_o        (rd_addr_col),
      .mask_o       (beat_mask)
   );

   dscml_burst_addr u_wr_addr (
      .start_i      (s_reg.wr_col),
      .beat_i       (s_reg.wr_beat),
      .len_code_i   (s_reg.mode[dscml_pkg::MR_BL_LSB +: 3]),
      .interleave_i (s_reg.mode[dscml_pkg::MR_BT]),
      .col_o        (wr_addr_col),
      .mask_o       ()
   );

   // Storage keeps only low column bits per bank; rows alias onto each other
   dscml_mem #(
      .AW (MEM_AW),
      .DW (dscml_pkg::DQ_W)
   ) u_mem (
      .clk_i   (CORE_CLK_I),
      .rst_n_i (RESET_N_I),
      .we_i    (mem_we),
      .waddr_i ({s_reg.wr_bank, wr_addr_col[MEM_AW-3:0]}),
      .wdata_i (s_reg.s2.dq),
      .raddr_i ({s_reg.rd_bank, rd_addr_col[MEM_AW-3:0]}),
      .rdata_o (mem_rdata)
   );

   always_comb begin
      s_next       = s_reg;
      mem_we       = 1'b0;
      s_next.s1    = pins_in;
      s_next.s2    = s_reg.s1;
      s_next.ck_d  = s_reg.s2.ck;
      s_next.dqs_d = s_reg.s2.dqs;

      // Read pipeline advances on both link clock edges
      if (ck_edge && s_reg.rd_act) begin
         if (!s_reg.rd_out) begin
            if (s_reg.rd_wait == 3'h1) begin
               s_next.rd_out  = 1'b1;
               s_next.rd_beat = 3'h0;
            end else begin
               s_next.rd_wait = s_reg.rd_wait - 3'h1;
            end
         end else if (s_reg.rd_beat == beat_mask) begin
            s_next.rd_act = 1'b0;
            s_next.rd_out = 1'b0;
            if (s_reg.rd_ap) begin
               s_next.open[s_reg.rd_bank] = 1'b0;
            end
         end else begin
            s_next.rd_beat = s_reg.rd_beat + 3'h1;
         end
      end

      // Write beats are taken on either strobe edge
      if (dqs_edge && s_reg.wr_act) begin
         mem_we = ~s_reg.s2.dm;
         s_next.wr_beat = s_reg.wr_beat + 3'h1;
         if (s_reg.wr_beat == beat_mask) begin
            s_next.wr_act = 1'b0;
            if (s_reg.wr_ap) begin
               s_next.open[s_reg.wr_bank] = 1'b0;
            end
         end
      end

      if (ck_rise) begin
         if (s_reg.dll_cnt != DLL_LOCK && !s_reg.emode[dscml_pkg::EMR_DLL_DIS]) begin
            s_next.dll_cnt = s_reg.dll_cnt + 8'h01;
         end
         if (s_reg.self_ref) begin
            if (s_reg.s2.cke) begin
               s_next.self_ref = 1'b0;
               s_next.emode[dscml_pkg::EMR_DLL_DIS] = 1'b0;
               s_next.dll_cnt = 8'h00;
            end
         end else if (s_reg.en) begin
            if (!s_reg.s2.cke) begin
               // Only refresh is legal with CKE low
               if (cmd == dscml_pkg::DSCML_REF) begin
                  s_next.self_ref = 1'b1;
                  s_next.last_cmd = cmd;
               end
            end else begin
               if (cmd != dscml_pkg::DSCML_NOP) begin
                  s_next.last_cmd = cmd;
               end
               unique case (cmd)
                  dscml_pkg::DSCML_NOP: begin
                  end
                  dscml_pkg::DSCML_ACT: begin
                     s_next.open[s_reg.s2.ba] = 1'b1;
                     s_next.rows[s_reg.s2.ba] = s_reg.s2.a;
                  end
                  dscml_pkg::DSCML_RD: begin
                     s_next.rd_act  = 1'b1;
                     s_next.rd_out  = 1'b0;
                     s_next.rd_wait = lat_half;
                     s_next.rd_bank = s_reg.s2.ba;
                     s_next.rd_col  = s_reg.s2.a[9:0];
                     s_next.rd_ap   = s_reg.s2.a[dscml_pkg::ADDR_AP];
                     s_next.rd_beat = 3'h0;
                  end
                  dscml_pkg::DSCML_WR: begin
                     s_next.wr_act  = 1'b1;
                     s_next.wr_bank = s_reg.s2.ba;
                     s_next.wr_col  = s_reg.s2.a[9:0];
                     s_next.wr_ap   = s_reg.s2.a[dscml_pkg::ADDR_AP];
                     s_next.wr_beat = 3'h0;
                  end
                  dscml_pkg::DSCML_BST: begin
                     // Undefined for auto-precharge reads, so those run on
                     if (s_reg.rd_act && !s_reg.rd_ap) begin
                        s_next.rd_act = 1'b0;
                        s_next.rd_out = 1'b0;
                     end
                  end
                  dscml_pkg::DSCML_PRE: begin
                     if (s_reg.s2.a[dscml_pkg::ADDR_AP]) begin
                        s_next.open = 4'h0;
                     end else begin
                        s_next.open[s_reg.s2.ba] = 1'b0;
                     end
                  end
                  dscml_pkg::DSCML_REF: begin
                     s_next.ref_row = s_reg.ref_row + 13'h0001;
                  end
                  dscml_pkg::DSCML_LMR: begin
                     if (s_reg.s2.ba == 2'h0) begin
                        // Reset bit is acted on and never stored
                        s_next.mode = s_reg.s2.a;
                        s_next.mode[dscml_pkg::MR_DLL_RST] = 1'b0;
                        if (s_reg.s2.a[dscml_pkg::MR_DLL_RST]) begin
                           s_next.dll_cnt = 8'h00;
                        end
                     end else if (s_reg.s2.ba == 2'h1) begin
                        s_next.emode = s_reg.s2.a;
                        if (s_reg.emode[dscml_pkg::EMR_DLL_DIS] &&
                            !s_reg.s2.a[dscml_pkg::EMR_DLL_DIS]) begin
                           s_next.dll_cnt = 8'h00;
                        end
                     end
                  end
               endcase
            end
         end
      end

      // Strobe and enable wait one cycle so they line up with the registered memory read
      s_next.dq_o     = mem_rdata;
      s_next.rd_out_d = s_reg.rd_out;
      s_next.dqs_ph   = s_reg.rd_out & ~s_reg.rd_beat[0];
      s_next.dq_oe    = s_reg.rd_out_d;
      s_next.dqs_oe   = s_reg.rd_out_d;
      s_next.dqs_o    = s_reg.dqs_ph;

      // One wait state: answer in the second access cycle
      s_next.pready  = 1'b0;
      s_next.pslverr = 1'b0;
      if (PSEL_I && PENABLE_I && !s_reg.pready) begin
         s_next.pready = 1'b1;
         s_next.prdata = 32'h0000_0000;
         if (PWRITE_I) begin
            if (PADDR_I == dscml_pkg::OFS_CTRL) begin
               s_next.en = PWDATA_I[dscml_pkg::CTRL_EN];
            end else begin
               s_next.pslverr = 1'b1;
            end
         end else if (PADDR_I[7:4] == dscml_pkg::OFS_ROWS_HI && PADDR_I[1:0] == 2'h0) begin
            s_next.prdata = {19'h00000, s_reg.rows[PADDR_I[3:2]]};
         end else begin
            unique case (PADDR_I)
               dscml_pkg::OFS_CTRL:   s_next.prdata = {31'h00000000, s_reg.en};
               dscml_pkg::OFS_MODE:   s_next.prdata = {19'h00000, s_reg.mode};
               dscml_pkg::OFS_EMODE:  s_next.prdata = {19'h00000, s_reg.emode};
               dscml_pkg::OFS_REFROW: s_next.prdata = {19'h00000, s_reg.ref_row};
               dscml_pkg::OFS_STATUS: begin
                  s_next.prdata[dscml_pkg::ST_DLL_READY] = dll_ready;
                  s_next.prdata[dscml_pkg::ST_SELF_REF]  = s_reg.self_ref;
                  s_next.prdata[dscml_pkg::ST_RD_ACT]    = s_reg.rd_act;
                  s_next.prdata[dscml_pkg::ST_WR_ACT]    = s_reg.wr_act;
                  s_next.prdata[dscml_pkg::ST_OPEN_LSB +: 4] = s_reg.open;
                  s_next.prdata[dscml_pkg::ST_CMD_LSB +: 3]  = s_reg.last_cmd;
               end
               default: s_next.pslverr = 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         s_reg       <= '0;
         s_reg.mode  <= dscml_pkg::MODE_RST;
         s_reg.emode <= dscml_pkg::EMODE_RST;
         s_reg.en    <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign DQ_O      = s_reg.dq_o;
   assign DQ_OE_O   = s_reg.dq_oe;
   assign DQS_O     = s_reg.dqs_o;
   assign DQS_OE_O  = s_reg.dqs_oe;
   assign PRDATA_O  = s_reg.prdata;
   assign PREADY_O  = s_reg.pready;
   assign PSLVERR_O = s_reg.pslverr;

endmodule

// file: dscml_sva.sv
`timescale 1ns/1ps
module dscml_sva (
   input wire logic       CORE_CLK_I,
   input wire logic       RESET_N_I,
   input wire logic       PSEL_I,
   input wire logic       PENABLE_I,
   input wire logic       PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic       PREADY_O,
   input wire logic       PSLVERR_O,
   input wire logic [7:0] DQ_O,
   input wire logic       DQ_OE_O,
   input wire logic       DQS_O,
   input wire logic       DQS_OE_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   sequence s_req; PSEL_I && PENABLE_I && !PREADY_O; endsequence
   sequence s_ans; PREADY_O ##1 !PREADY_O; endsequence
   property p_ans; s_req |=> s_ans; endproperty
   a_ans: assert property (p_ans) else $error("ready late");
   property p_cause; PREADY_O |-> $past(PSEL_I && PENABLE_I); endproperty
   a_cause: assert property (p_cause) else $error("ready without access");
   property p_err; PSLVERR_O |-> PREADY_O; endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_wr; PREADY_O && PWRITE_I |-> PSLVERR_O == (PADDR_I != 8'h00); endproperty
   a_wr: assert property (p_wr) else $error("write error flag wrong");
   property p_first; $rose(DQ_OE_O) |-> DQS_OE_O && DQS_O; endproperty
   a_first: assert property (p_first) else $error("first beat strobe low");
   property p_half; DQ_OE_O && $changed(DQS_O) |=> $stable(DQS_O) [*8]; endproperty
   a_half: assert property (p_half) else $error("beat too short");
   property p_hold; DQ_OE_O && $past(DQ_OE_O) && $stable(DQS_O) |-> $stable(DQ_O); endproperty
   a_hold: assert property (p_hold) else $error("data moved inside beat");
   property p_last; $fell(DQ_OE_O) |-> $past(!DQS_O); endproperty
   a_last: assert property (p_last) else $error("odd beat count");
endmodule
bind dscml_top dscml_sva dscml_sva_inst (.CORE_CLK_I, .RESET_N_I, .PSEL_I, .PENABLE_I,
   .PWRITE_I, .PADDR_I, .PREADY_O, .PSLVERR_O, .DQ_O, .DQ_OE_O, .DQS_O, .DQS_OE_O);

// file: dscml_ctl_model.sv
`timescale 1ns/1ps
module dscml_ctl_model (
   output dscml_pkg::dscml_pins_t pins_o
);
   real t_cmd;
   initial begin
      pins_o = '0;
      pins_o.cke = 1'b1;
      {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = 4'hF;
      #13.3;
      forever #80 pins_o.ck = ~pins_o.ck;
   end
   // Pins move on the falling link edge so they stand still around each rise
   task automatic cmd(input logic [3:0] c, input logic [1:0] ba, input logic [12:0] a);
      @(negedge pins_o.ck);
      {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = c;
      pins_o.ba = ba;
      pins_o.a = a;
      t_cmd = $realtime + 80.0;
      @(negedge pins_o.ck);
      {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = 4'h7;
      pins_o.a = ~a;
   endtask
   // Data is centred on each strobe edge; released data shows its inverse
   task automatic wr(input logic [1:0] ba, input logic [63:0] d, input logic [7:0] m);
      cmd(4'h4, ba, 13'h0000);
      for (int i = 0; i < 8; i++) begin
         #40 pins_o.dq = d[8*i+:8];
         pins_o.dm = m[i];
         #40 pins_o.dqs = ~pins_o.dqs;
      end
      #40 pins_o.dq = ~pins_o.dq;
   endtask
   // No burst terminate task: writes and auto-precharge reads must never get one
   task automatic set_cke(input logic v);
      @(negedge pins_o.ck);
      pins_o.cke = v;
   endtask
endmodule

// file: dscml_top_tb.sv
`timescale 1ns/1ps
module dscml_top_tb;
   logic                   clk, rst_n, psel, pen, pwr, rdy, err, oe, dqs, oe_q, dqs_q, qoe;
   logic [7:0]             padr, dq;
   logic [31:0]            pwd, prd, rs;
   logic [7:0]             q[$];
   real                    t_oe;
   int                     n_fail, n_tests;
   dscml_pkg::dscml_pins_t pn;
   dscml_ctl_model ctl (.pins_o(pn));
   dscml_top #(.DLL_LOCK_CYCLES(8)) dscml_top_inst (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
      .CK_I(pn.ck), .CKE_I(pn.cke), .CS_N_I(pn.cs_n), .RAS_N_I(pn.ras_n), .CAS_N_I(pn.cas_n),
      .WE_N_I(pn.we_n), .BA_I(pn.ba), .A_I(pn.a), .DQ_I(pn.dq), .DQ_O(dq), .DQ_OE_O(oe),
      .DM_I(pn.dm), .DQS_I(pn.dqs), .DQS_O(dqs), .DQS_OE_O(qoe), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy),
      .PSLVERR_O(err));
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic print_verdict();
      if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic lim(input int n, input int mx);
      if (n >= mx) begin
         n_fail++;
         print_verdict();
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                      output logic [31:0] rd, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      padr <= ad;
      pwd <= wd;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 50);
      lim(n, 50);
      rd = prd;
      e = err;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] ad, input logic [31:0] e, input logic ee);
      logic [31:0] d;
      logic        x;
      apb(1'b0, ad, 32'h0, d, x);
      check("prdata", d, e);
      check("pslverr", 32'(x), 32'(ee));
   endtask
   task automatic stat(output logic [31:0] d);
      logic x;
      apb(1'b0, 8'h0C, 32'h0, d, x);
   endtask
   task automatic dll_wait();
      logic [31:0] d;
      int          n;
      n = 0;
      do begin
         stat(d);
         n++;
      end while (d[0] !== 1'b1 && n < 400);
      lim(n, 400);
   endtask
   // A beat starts when the strobe toggles, so repeated data values still count
   always @(posedge clk) begin
      if (oe === 1'b1 && (oe_q !== 1'b1 || dqs !== dqs_q)) begin
         if (oe_q !== 1'b1) t_oe = $realtime;
         if (q.size() == 0) check("extra beat", 32'h1, 32'h0);
         else check("beat", 32'(dq), 32'(q.pop_front()));
      end
      if (oe !== oe_q) check("strobe enable", 32'(qoe), 32'(oe));
      oe_q <= oe;
      dqs_q <= dqs;
   end
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      logic [63:0] d0, d1;
      logic [31:0] r, row;
      logic        x;
      logic [2:0]  bl, cl;
      int          len, s, c, n;
      real         lat;
      rs = 32'h0000C152;
      {rst_n, psel, pen, pwr, padr, pwd, oe_q, dqs_q} = '0;
      n_fail = 0;
      n_tests = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(8'h00, 32'h1, 1'b0);
      rdchk(8'h04, 32'h0, 1'b0);
      rdchk(8'h14, 32'h0, 1'b1);
      apb(1'b1, 8'h04, xs(), r, x);
      check("ro write", 32'(x), 32'h1);
      apb(1'b1, 8'h00, 32'h1, r, x);
      check("ctrl write", 32'(x), 32'h0);
      ctl.cmd(4'h0, 2'h1, 13'h0002);
      rdchk(8'h08, 32'h2, 1'b0);
      ctl.cmd(4'h0, 2'h2, 13'h1FFF);
      rdchk(8'h04, 32'h0, 1'b0);
      r = {19'h0, 6'h00, dscml_pkg::CL_2, 1'b0, dscml_pkg::BL_8};
      ctl.cmd(4'h0, 2'h0, r[12:0] | 13'h0100);
      rdchk(8'h04, r, 1'b0);
      ctl.cmd(4'h0, 2'h0, r[12:0]);
      row = xs();
      ctl.cmd(4'h3, 2'h1, row[12:0]);
      rdchk(8'h24, {19'h0, row[12:0]}, 1'b0);
      d0 = {xs(), xs()};
      d1 = {xs(), xs()};
      ctl.wr(2'h1, d0, 8'h00);
      ctl.wr(2'h1, d1, 8'h08);
      dll_wait();
      for (int k = 0; k < 3; k++) begin
         bl = 3'(3 - k);
         cl = (k == 1) ? dscml_pkg::CL_2P5 : dscml_pkg::CL_2;
         len = 8 >> k;
         s = 5 + k;
         ctl.cmd(4'h0, 2'h0, {6'h00, cl, (k == 0), bl});
         for (int i = 0; i < len; i++) begin
            c = (s & ~(len - 1)) | (((k == 0) ? (s ^ i) : (s + i)) & (len - 1));
            q.push_back((c == 3) ? d0[8*c+:8] : d1[8*c+:8]);
         end
         ctl.cmd(4'h5, 2'h1, 13'(s));
         n = 0;
         while ((q.size() > 0 || oe !== 1'b0) && n < 3000) begin
            @(posedge clk);
            n++;
         end
         lim(n, 3000);
         lat = t_oe - ctl.t_cmd - ((k == 1) ? 400.0 : 320.0);
         check("latency", 32'(lat >= 0.0 && lat < 60.0), 32'h1);
      end
      ctl.cmd(4'h3, 2'h2, 13'h0000);
      ctl.cmd(4'h2, 2'h1, 13'h0000);
      stat(r);
      check("open banks", 32'(r[7:4]), 32'h4);
      ctl.cmd(4'h2, 2'h3, 13'h0400);
      ctl.cmd(4'h1, 2'h0, 13'h0000);
      stat(r);
      check("all closed", 32'(r[7:4]), 32'h0);
      check("last cmd", 32'(r[10:8]), 32'h6);
      ctl.set_cke(1'b0);
      ctl.cmd(4'h1, 2'h0, 13'h0000);
      stat(r);
      check("self refresh", 32'(r[1]), 32'h1);
      ctl.set_cke(1'b1);
      ctl.cmd(4'h7, 2'h0, 13'h0000);
      stat(r);
      check("exit", 32'(r[1:0]), 32'h0);
      dll_wait();
      print_verdict();
   end
endmodule
